//--- src/hsp_protection_ctrl.sv
// hot standby protection controller: roles, trigger ranking, revert timer, mate config
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "hsp_defines.svh"
//
// Summary of operation
// [RL1] one carrier active, other standby; standby takes over
// [RL2] carriers report status; host alone orders switchover (the code also switches on revert timer expiry with no host order)
// [RL3] periodic config compare, independent of protection
// [RL4] differing configs raise mate mismatch alarm
// [RL5] identical configs clear mate mismatch alarm
// [RL6] copy-to-mate copies whole active config to standby
// [RL7] paired mode mirrors every active config write
// [RL8] both carriers use identical outdoor radio units
// [RL9] revertive mode with user-selected primary radio
// [RL10] ten-minute timer runs while primary qualifies, secondary active
// [RL11] timer expiry returns active role to primary
// [RL12] each revertive switch logs one event
// [RL13] ranking: missing, lockout, force, failure, manual
// [RL14] primary losing qualification cancels and restarts timer
// [RL15] only highest-ranked trigger acts, never overridden
//
module hsp_protection_ctrl #(
    parameter logic [35:0] REVERT_CYCLES =
        36'(64'(`HSP_REVERT_TIME_MIN) * 64'd60 * 64'(`HSP_CLK_HZ)),
    parameter logic [23:0] CMP_INTERVAL =
        24'(64'(`HSP_CMP_PERIOD_MS) * 64'(`HSP_CLK_HZ) / 64'd1000)
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [`HSP_ADDR_W-1:0] regAddr,
    input wire logic [`HSP_DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [`HSP_DATA_W-1:0] regRdData,
    input wire logic [1:0] carMissing,
    input wire logic [1:0] carFail,
    input wire logic [1:0] carAvail,
    output logic activeCarrier,
    output logic mateMismatch,
    output logic revertEvent,
    output hsp_pkg::hsp_trig_type pendingTrigger
);
    import hsp_pkg::*;

    // ---------------- carrier status pins ----------------
    logic [5:0] statSync; // synchronised missing, fail and available levels
    logic [1:0] missS; // module missing per carrier
    logic [1:0] failS; // traffic failure per carrier
    logic [1:0] availS; // operational, available, alarm free per carrier

    // status pins come from the carriers' own logic, so they are synchronised first
    hsp_sync #(
        .W(6)
    ) u_sync (
        .clock(clock),
        .srst(srst),
        .din({carAvail, carFail, carMissing}),
        .dout(statSync)
    );

    assign missS = statSync[1:0];
    assign failS = statSync[3:2];
    assign availS = statSync[5:4];

    // ---------------- register decode ----------------
    logic [`HSP_CTRL_W-1:0] ctrl_r; // software control bits
    logic [`HSP_CFG_AW:0] cfgAddr_r; // config word index plus mate select
    logic [`HSP_EVT_W-1:0] evtCnt_r; // revertive switch log count
    logic act_r; // carrier that holds the active role
    logic mismatch_r; // mate configuration mismatch alarm
    logic revEvt_r; // one-cycle revertive switch marker
    hsp_trig_type trig_r; // registered view of the winning trigger
    hsp_walk_type walk_r; // configuration walker state
    logic [35:0] revCnt_r; // revertive timer
    logic [`HSP_DATA_W-1:0] rdData_r; // read data register

    wire logic selCtrl = (regAddr == `HSP_REG_CTRL);
    wire logic selCmd = (regAddr == `HSP_REG_CMD);
    wire logic selCfgAddr = (regAddr == `HSP_REG_CFG_ADDR);
    wire logic selCfgData = (regAddr == `HSP_REG_CFG_DATA);
    wire logic selStatus = (regAddr == `HSP_REG_STATUS);
    wire logic selEvt = (regAddr == `HSP_REG_EVT_CNT);

    wire logic wrCtrl = regWr && selCtrl;
    wire logic wrCfgAddr = regWr && selCfgAddr;
    wire logic goCmd = regWr && selCmd && regWrData[`HSP_CMD_GO];
    wire logic copyCmd = regWr && selCmd && regWrData[`HSP_CMD_COPY];
    wire logic copyBusy = (walk_r == WALK_COPY);
    // config writes are refused while a copy owns the mate store
    wire logic cfgWr = regWr && selCfgData && !copyBusy;

    // control fields
    wire logic revertEn = ctrl_r[`HSP_CTRL_REVERT_EN];
    wire logic primSel = ctrl_r[`HSP_CTRL_PRIMARY];
    wire logic pairEn = ctrl_r[`HSP_CTRL_PAIR_EN];
    wire logic lockoutReq = ctrl_r[`HSP_CTRL_LOCKOUT];
    wire logic forceReq = ctrl_r[`HSP_CTRL_FORCE];
    wire logic manualReq = ctrl_r[`HSP_CTRL_MANUAL];
    wire logic reqTarget = ctrl_r[`HSP_CTRL_TARGET];

    // ---------------- switchover triggers ----------------
    wire logic sby = ~act_r; // standby carrier
    wire logic sbyHealthy = !missS[sby] && !failS[sby];
    // each trigger except lockout only counts when it would move the active role
    wire logic hwTrig = missS[act_r] && !missS[sby];
    wire logic lockTrig = lockoutReq;
    wire logic forceTrig = forceReq && (reqTarget != act_r);
    wire logic failTrig = failS[act_r] && sbyHealthy;
    wire logic manTrig = manualReq && (reqTarget != act_r) && sbyHealthy;

    // fixed priority chain; a lower trigger is seen only when all above are absent
    wire hsp_trig_type trigWin = hwTrig ? TRG_HWMISS : // RL13
                                 lockTrig ? TRG_LOCK :
                                 forceTrig ? TRG_FORCE :
                                 failTrig ? TRG_TFAIL :
                                 manTrig ? TRG_MANUAL : TRG_NONE; // RL15
    // lockout wins over force, failure and manual but moves nothing itself
    wire logic switchNeed = (trigWin != TRG_NONE) && (trigWin != TRG_LOCK); // RL15

    // ---------------- revertive timer ----------------
    // primary must be present, failure free, available, and standing as secondary;
    // any pending trigger (lockout included) holds the timer at zero
    wire logic primReady = !missS[primSel] && !failS[primSel] && availS[primSel];
    wire logic revQual = revertEn && (act_r != primSel) && primReady
                         && (trigWin == TRG_NONE); // RL10
    wire logic revExpire = revQual && (revCnt_r == REVERT_CYCLES - 36'h0_0000_0001); // RL11
    // host order executes the winning trigger; revert needs no order
    wire logic doSwitch = (goCmd && switchNeed) || revExpire; // RL2

    // timer restarts from zero whenever the primary drops out of qualification
    always_ff @(posedge clock) begin
        if (srst || !revQual) begin
            revCnt_r <= '0; // RL14
        end else if (revExpire) begin
            revCnt_r <= '0;
        end else begin
            revCnt_r <= revCnt_r + 36'h0_0000_0001; // RL10
        end
    end

    // active role; carrier 0 starts active, a switch hands the role to the mate
    always_ff @(posedge clock) begin
        if (srst) begin
            act_r <= 1'b0;
        end else if (doSwitch) begin
            act_r <= ~act_r; // RL1
        end
    end

    // event log: pulse plus running count, one entry per revertive switch
    always_ff @(posedge clock) begin
        if (srst) begin
            revEvt_r <= 1'b0;
            evtCnt_r <= '0;
        end else begin
            revEvt_r <= revExpire; // RL12
            evtCnt_r <= evtCnt_r + `HSP_EVT_W'(revExpire); // RL12
        end
    end

    // winning trigger is published so the host can decide on it
    always_ff @(posedge clock) begin
        if (srst) begin
            trig_r <= TRG_NONE;
        end else begin
            trig_r <= trigWin; // RL2
        end
    end

    // ---------------- control registers ----------------
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_r <= `HSP_CTRL_RST;
            cfgAddr_r <= '0;
        end else begin
            if (wrCtrl) begin
                ctrl_r <= regWrData[`HSP_CTRL_W-1:0]; // RL9
            end
            if (wrCfgAddr) begin
                cfgAddr_r <= regWrData[`HSP_CFG_AW:0];
            end
        end
    end

    // ---------------- configuration stores ----------------
    logic [`HSP_CFG_DW-1:0] localRd; // active carrier config word
    logic [`HSP_CFG_DW-1:0] mateRd; // standby carrier config word
    logic [`HSP_CFG_AW:0] walkCnt_r; // walk index, top bit marks all issued
    logic pipeValid_r; // read data of the previous index are present
    logic [`HSP_CFG_AW-1:0] pipeAddr_r; // index of those read data
    logic copyPend_r; // copy ordered, not yet started
    logic cmpPend_r; // periodic check due, not yet started
    logic diff_r; // difference seen during the current check
    logic [23:0] intCnt_r; // check interval counter

    wire logic [`HSP_CFG_AW-1:0] walkAddr = walkCnt_r[`HSP_CFG_AW-1:0];
    wire logic issuing = (walk_r != WALK_IDLE) && !walkCnt_r[`HSP_CFG_AW];
    wire logic walkDone = (walk_r != WALK_IDLE) && walkCnt_r[`HSP_CFG_AW] && !pipeValid_r;
    wire logic copyWr = copyBusy && pipeValid_r; // RL6
    wire logic localWe = cfgWr && !cfgAddr_r[`HSP_CFG_MATE_SEL];
    // in paired mode a write to the active store lands in the mate as well
    wire logic cpuMateWe = cfgWr && (cfgAddr_r[`HSP_CFG_MATE_SEL] || pairEn); // RL7
    wire logic mateWe = copyWr || cpuMateWe;
    wire logic [`HSP_CFG_AW-1:0] mateWrAddr = copyWr ? pipeAddr_r : cfgAddr_r[`HSP_CFG_AW-1:0];
    wire logic [`HSP_CFG_DW-1:0] mateWrData = copyWr ? localRd : regWrData[`HSP_CFG_DW-1:0];
    wire logic cmpTick = (intCnt_r == CMP_INTERVAL - 24'h00_0001);
    wire logic startCopy = (walk_r == WALK_IDLE) && copyPend_r;
    wire logic startCmp = (walk_r == WALK_IDLE) && !copyPend_r && cmpPend_r;

    hsp_cfg_mem u_local (
        .clock(clock),
        .srst(srst),
        .wrEn(localWe),
        .wrAddr(cfgAddr_r[`HSP_CFG_AW-1:0]),
        .wrData(regWrData[`HSP_CFG_DW-1:0]),
        .rdAddr(walkAddr),
        .rdData(localRd)
    );

    hsp_cfg_mem u_mate (
        .clock(clock),
        .srst(srst),
        .wrEn(mateWe),
        .wrAddr(mateWrAddr),
        .wrData(mateWrData),
        .rdAddr(walkAddr),
        .rdData(mateRd)
    );

    // free-running interval, unrelated to role or trigger state
    always_ff @(posedge clock) begin
        if (srst || cmpTick) begin
            intCnt_r <= '0;
        end else begin
            intCnt_r <= intCnt_r + 24'h00_0001; // RL3
        end
    end

    // pending requests: a new request in the start cycle is kept (set wins)
    always_ff @(posedge clock) begin
        if (srst) begin
            copyPend_r <= 1'b0;
            cmpPend_r <= 1'b0;
        end else begin
            copyPend_r <= copyCmd || (copyPend_r && !startCopy); // RL6
            cmpPend_r <= cmpTick || (cmpPend_r && !startCmp); // RL3
        end
    end

    // walker: copy has precedence so a fresh copy is checked by the next pass
    always_ff @(posedge clock) begin
        if (srst) begin
            walk_r <= WALK_IDLE;
        end else begin
            case (walk_r)
                WALK_IDLE: begin
                    if (startCopy) begin
                        walk_r <= WALK_COPY;
                    end else if (startCmp) begin
                        walk_r <= WALK_CMP;
                    end
                end
                WALK_COPY, WALK_CMP: begin
                    if (walkDone) begin
                        walk_r <= WALK_IDLE;
                    end
                end
                default: begin
                    walk_r <= WALK_IDLE;
                end
            endcase
        end
    end

    // index and read pipeline; index parks at zero while idle
    always_ff @(posedge clock) begin
        if (srst || walk_r == WALK_IDLE) begin
            walkCnt_r <= '0;
        end else if (issuing) begin
            walkCnt_r <= walkCnt_r + 5'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pipeValid_r <= 1'b0;
            pipeAddr_r <= '0;
        end else begin
            pipeValid_r <= issuing;
            pipeAddr_r <= walkAddr;
        end
    end

    // word-by-word comparison of the two stores
    always_ff @(posedge clock) begin
        if (srst || startCmp) begin
            diff_r <= 1'b0;
        end else if (walk_r == WALK_CMP && pipeValid_r && localRd != mateRd) begin
            diff_r <= 1'b1; // RL3
        end
    end

    // alarm follows each finished check: raised on a difference, cleared when equal;
    // a host write landing mid-check is seen by that pass only if its word is not yet read
    always_ff @(posedge clock) begin
        if (srst) begin
            mismatch_r <= 1'b0;
        end else if (walk_r == WALK_CMP && walkDone) begin
            if (diff_r) begin
                mismatch_r <= 1'b1; // RL4
            end else begin
                mismatch_r <= 1'b0; // RL5
            end
        end
    end

    // ---------------- read back ----------------
    wire logic [`HSP_DATA_W-1:0] statusWord =
        (32'(act_r) << `HSP_ST_ACTIVE) |
        (32'(mismatch_r) << `HSP_ST_MISMATCH) |
        (32'(walk_r != WALK_IDLE) << `HSP_ST_BUSY) |
        (32'(trig_r) << `HSP_ST_TRIG_LO) |
        (32'(revQual) << `HSP_ST_REV_RUN) |
        (32'(missS) << `HSP_ST_MISS_LO) |
        (32'(failS) << `HSP_ST_FAIL_LO) |
        (32'(availS) << `HSP_ST_AVAIL_LO); // RL2
    wire logic [`HSP_DATA_W-1:0] rdMux =
        selCtrl ? 32'(ctrl_r) :
        selCfgAddr ? 32'(cfgAddr_r) :
        selStatus ? statusWord :
        selEvt ? 32'(evtCnt_r) : 32'h0000_0000;

    // data stand for exactly the cycle after the read strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (srst) begin
            rdData_r <= '0;
        end else begin
            rdData_r <= regRd ? rdMux : 32'h0000_0000;
        end
    end

    assign regRdData = rdData_r;
    assign activeCarrier = act_r;
    assign mateMismatch = mismatch_r;
    assign revertEvent = revEvt_r;
    assign pendingTrigger = trig_r;
endmodule

//--- src/hsp_defines.svh
// register offsets, field positions, sizes and timing constants of the protection controller
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH
`define HSP_ADDR_W 8
`define HSP_DATA_W 32
`define HSP_REG_CTRL 8'h00
`define HSP_REG_CMD 8'h04
`define HSP_REG_CFG_ADDR 8'h08
`define HSP_REG_CFG_DATA 8'h0C
`define HSP_REG_STATUS 8'h10
`define HSP_REG_EVT_CNT 8'h14
`define HSP_CTRL_REVERT_EN 0
`define HSP_CTRL_PRIMARY 1
`define HSP_CTRL_PAIR_EN 2
`define HSP_CTRL_LOCKOUT 3
`define HSP_CTRL_FORCE 4
`define HSP_CTRL_MANUAL 5
`define HSP_CTRL_TARGET 6
`define HSP_CTRL_W 7
`define HSP_CTRL_RST 7'h00
`define HSP_CMD_GO 0
`define HSP_CMD_COPY 1
`define HSP_CFG_MATE_SEL 4
`define HSP_CFG_AW 4
`define HSP_CFG_DW 16
`define HSP_ST_ACTIVE 0
`define HSP_ST_MISMATCH 1
`define HSP_ST_BUSY 2
`define HSP_ST_TRIG_LO 3
`define HSP_ST_REV_RUN 6
`define HSP_ST_MISS_LO 8
`define HSP_ST_FAIL_LO 10
`define HSP_ST_AVAIL_LO 12
`define HSP_EVT_W 16
`define HSP_CLK_HZ 40000000
`define HSP_REVERT_TIME_MIN 10
`define HSP_CMP_PERIOD_MS 1
`endif

//--- src/hsp_pkg.sv
// types shared by the protection controller files
package hsp_pkg;
    // switchover trigger, ranked: lower code means higher priority
    typedef enum logic [2:0] {
        TRG_NONE = 3'b000,
        TRG_HWMISS = 3'b001,
        TRG_LOCK = 3'b010,
        TRG_FORCE = 3'b011,
        TRG_TFAIL = 3'b100,
        TRG_MANUAL = 3'b101
    } hsp_trig_type;
    // configuration walker states
    typedef enum logic [1:0] {
        WALK_IDLE = 2'b00,
        WALK_COPY = 2'b01,
        WALK_CMP = 2'b10
    } hsp_walk_type;
endpackage

//--- src/hsp_sync.sv
// two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module hsp_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r; // first stage, read only by the second stage

    // both stages clear to zero so a missing pin reads as healthy at start
    always_ff @(posedge clock) begin
        if (srst) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

//--- src/hsp_cfg_mem.sv
// small configuration store: one write port, one registered read port
`timescale 1ns/1ps
`include "hsp_defines.svh"
module hsp_cfg_mem (
    input wire logic clock,
    input wire logic srst,
    input wire logic wrEn,
    input wire logic [`HSP_CFG_AW-1:0] wrAddr,
    input wire logic [`HSP_CFG_DW-1:0] wrData,
    input wire logic [`HSP_CFG_AW-1:0] rdAddr,
    output logic [`HSP_CFG_DW-1:0] rdData
);
    // array holds no reset; both carriers start with the same unknown-free content only
    // once software has written them, so the first check may flag a mismatch
    logic [`HSP_CFG_DW-1:0] mem [0:(1<<`HSP_CFG_AW)-1];

    // write port
    always_ff @(posedge clock) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // read data leave through a register, one cycle after the address
    always_ff @(posedge clock) begin
        if (srst) begin
            rdData <= '0;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule

//--- sim/hsp_protection_ctrl_checker.sv
// concurrent checks on the protection controller ports
`timescale 1ns/1ps
`include "hsp_defines.svh"
module hsp_protection_ctrl_checker #(
    parameter logic [35:0] REVERT_CYCLES = 36'h0_0000_0064,
    parameter logic [23:0] CMP_INTERVAL = 24'h00_0040
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic [1:0] carMissing,
    input wire logic [1:0] carFail,
    input wire logic [1:0] carAvail,
    input wire logic activeCarrier,
    input wire logic mateMismatch,
    input wire logic revertEvent,
    input wire hsp_pkg::hsp_trig_type pendingTrigger
);
    import hsp_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic primSel_r; // primary carrier as last written by the host
    logic [35:0] runLen_r; // cycles the primary's raw pins have qualified in a row
    // raw pins lead the synced view, so this run starts and ends no later than the design's
    always_ff @(posedge clock) begin
        if (srst) begin
            primSel_r <= 1'b0;
            runLen_r <= '0;
        end else if (regWr && regAddr == `HSP_REG_CTRL && regWrData[1] != primSel_r) begin
            primSel_r <= regWrData[1];
            runLen_r <= '0;
        end else if (carAvail[primSel_r] && !carFail[primSel_r] && !carMissing[primSel_r]) begin
            runLen_r <= runLen_r + 36'h1;
        end else begin
            runLen_r <= '0;
        end
    end
    // active carrier missing, mate present, nothing moving
    sequence s_miss_steady;
        (carMissing[activeCarrier] && !carMissing[~activeCarrier] && $stable(carMissing)
            && $stable(activeCarrier)) [*4];
    endsequence
    sequence s_lock_held;
        (pendingTrigger == TRG_LOCK) [*3];
    endsequence
    a_reset_outputs: assert property (disable iff (1'b0) srst |=>
        !activeCarrier && !mateMismatch && !revertEvent && pendingTrigger == TRG_NONE)
        else $error("outputs not at rest after reset");
    a_read_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data outside the read answer cycle");
    a_read_blank: assert property ($past(regRd) && ($past(regAddr) == `HSP_REG_CMD
        || $past(regAddr) > `HSP_REG_EVT_CNT) |-> regRdData == 32'h0)
        else $error("write-only or unmapped read not zero");
    // busy bit sits between mismatch and the trigger field, so it is stepped over
    a_status_view: assert property ($past(regRd) && $past(regAddr) == `HSP_REG_STATUS
        |-> {regRdData[5:3], regRdData[1:0]}
            == {$past(pendingTrigger), $past(mateMismatch), $past(activeCarrier)})
        else $error("status read disagrees with outputs");
    a_event_single: assert property (revertEvent |=> !revertEvent)
        else $error("revert event longer than one cycle");
    a_revert_target: assert property (revertEvent |-> ##[0:1] activeCarrier == primSel_r)
        else $error("revert did not land on the primary");
    a_revert_wait: assert property (revertEvent |-> runLen_r >= REVERT_CYCLES)
        else $error("revert before the primary qualified long enough");
    // a host order toggles the role at the edge that takes the command write
    a_role_cause: assert property ($changed(activeCarrier) |-> revertEvent
        || ($past(regWr) && $past(regAddr) == `HSP_REG_CMD))
        else $error("role moved without host order or revert");
    a_lock_holds: assert property (s_lock_held |-> $stable(activeCarrier))
        else $error("role moved under lockout");
    a_miss_first: assert property (s_miss_steady |-> pendingTrigger == TRG_HWMISS)
        else $error("missing module not ranked first");
endmodule
bind hsp_protection_ctrl hsp_protection_ctrl_checker #(
    .REVERT_CYCLES(REVERT_CYCLES),
    .CMP_INTERVAL(CMP_INTERVAL)
) hsp_protection_ctrl_checker_i (.*);

//--- sim/hsp_carrier_model.sv
// model of the two radio carriers reporting their status pins
`timescale 1ns/1ps
module hsp_carrier_model (
    input wire logic clock,
    input wire logic [1:0] setMissing,
    input wire logic [1:0] setFail,
    input wire logic [1:0] setAvail,
    output logic [1:0] carMissing,
    output logic [1:0] carFail,
    output logic [1:0] carAvail
);
    // both halves are the same unit type, so one model body serves both
    initial begin
        carMissing = 2'b00;
        carFail = 2'b00;
        carAvail = 2'b00;
    end
    // status changes on the falling edge: unrelated to the host's sampling edge
    always @(negedge clock) begin
        carMissing <= setMissing;
        carFail <= setFail;
        carAvail <= setAvail;
    end
endmodule

//--- sim/hot_standby_protection_ctrl_test.sv
// self-checking bench for the protection controller
`timescale 1ns/1ps
`include "hsp_defines.svh"
module hot_standby_protection_ctrl_test;
    import hsp_pkg::*;
    localparam logic [35:0] REV = 36'h0_0000_0064; // revert time cut to 100 cycles
    localparam logic [23:0] CMP = 24'h00_0040; // check every 64 cycles
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData;
    logic activeCarrier;
    logic mateMismatch;
    logic revertEvent;
    hsp_trig_type pendingTrigger;
    logic [1:0] carMissing, carFail, carAvail;
    logic [1:0] setMissing = 2'b00;
    logic [1:0] setFail = 2'b00;
    logic [1:0] setAvail = 2'b00;
    int failures = 0;
    int nChecks = 0;
    int evCount = 0;
    int cnt;
    logic [31:0] seed = 32'h781f_66a8;
    logic [31:0] d;
    logic [15:0] s;
    logic act, prim;
    hsp_trig_type e;
    logic [15:0] corner [4] = '{16'h01F1, 16'h017C, 16'h0144, 16'h0184}; // several-at-once cases
    always #12.5 clock = ~clock;
    hsp_protection_ctrl #(.REVERT_CYCLES(REV), .CMP_INTERVAL(CMP)) hsp_protection_ctrl_i (
        .clock(clock), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .carMissing(carMissing),
        .carFail(carFail), .carAvail(carAvail), .activeCarrier(activeCarrier),
        .mateMismatch(mateMismatch), .revertEvent(revertEvent),
        .pendingTrigger(pendingTrigger));
    hsp_carrier_model hsp_carrier_model_i (.clock(clock), .setMissing(setMissing),
        .setFail(setFail), .setAvail(setAvail), .carMissing(carMissing),
        .carFail(carFail), .carAvail(carAvail));
    // falling edge keeps the count clear of the pulse's own launch edge
    always @(negedge clock) begin
        if (revertEvent === 1'b1) evCount++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0);
    endfunction
    // ranked trigger the host should see for the given pin and request state
    function automatic hsp_trig_type texp(input logic a, input logic [15:0] v);
        if (v[a] && !v[!a]) return TRG_HWMISS;
        if (v[4] && v[5]) return TRG_LOCK;
        if (v[6] && v[8] != a) return TRG_FORCE;
        if (v[2 + a] && !v[!a] && !v[2 + !a]) return TRG_TFAIL;
        if (v[7] && v[8] != a && !v[!a] && !v[2 + !a]) return TRG_MANUAL;
        return TRG_NONE;
    endfunction
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        nChecks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    // read answer stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic cfgw(input logic sel, input logic [3:0] i, input logic [15:0] v);
        wr(`HSP_REG_CFG_ADDR, {27'h0, sel, i});
        wr(`HSP_REG_CFG_DATA, {16'h0, v});
    endtask
    // watchdog: whole run needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        finish_test();
    end
    initial begin
        idle(3);
        srst <= 1'b0;
        idle(1);
        check(activeCarrier, 1'b0);
        check(pendingTrigger, TRG_NONE);
        seed = lfsr(seed);
        wr(`HSP_REG_CTRL, seed);
        rd(`HSP_REG_CTRL, d);
        check(d, {25'h0, seed[6:0]});
        wr(`HSP_REG_CTRL, 32'h0);
        rd(`HSP_REG_CMD, d);
        check(d, 32'h0);
        rd(8'h18, d);
        check(d, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            cfgw(1'b0, i[3:0], seed[15:0]);
            cfgw(1'b1, i[3:0], seed[15:0]);
        end
        idle(200);
        check(mateMismatch, 1'b0);
        cfgw(1'b1, 4'h5, ~seed[15:0]);
        idle(200);
        check(mateMismatch, 1'b1);
        wr(`HSP_REG_CMD, 32'h2);
        idle(200);
        check(mateMismatch, 1'b0);
        wr(`HSP_REG_CTRL, 32'h4);
        cfgw(1'b0, 4'h3, ~seed[15:0]);
        idle(200);
        check(mateMismatch, 1'b0);
        wr(`HSP_REG_CTRL, 32'h0);
        cfgw(1'b0, 4'h3, seed[15:0]);
        idle(200);
        check(mateMismatch, 1'b1);
        wr(`HSP_REG_CMD, 32'h2);
        idle(200);
        check(mateMismatch, 1'b0);
        $display("test mate config done");
        act = 1'b0;
        setAvail <= 2'b11;
        for (int n = 0; n < 34; n++) begin
            seed = lfsr(seed);
            s = (n < 4) ? corner[n] : seed[15:0];
            setMissing <= s[1:0];
            setFail <= s[3:2];
            wr(`HSP_REG_CTRL, {25'h0, s[8:6], s[4] & s[5], 3'h0});
            idle(6);
            e = texp(act, s);
            check(pendingTrigger, e);
            wr(`HSP_REG_CMD, 32'h1);
            idle(4);
            if (e != TRG_NONE && e != TRG_LOCK) act = ~act;
            check(activeCarrier, act);
        end
        $display("test triggers done");
        wr(`HSP_REG_CTRL, 32'h0);
        setMissing <= 2'b00;
        setFail <= 2'b00;
        prim = ~act;
        wr(`HSP_REG_CTRL, {30'h0, prim, 1'b1});
        idle(50);
        setAvail <= 2'b00;
        idle(10);
        setAvail <= 2'b11;
        idle(20);
        rd(`HSP_REG_STATUS, d);
        check(d[`HSP_ST_REV_RUN], 1'b1);
        cnt = 22;
        while (revertEvent !== 1'b1 && cnt < 400) begin
            idle(1);
            cnt++;
        end
        check(cnt >= 100 && cnt <= 112, 1'b1);
        idle(2);
        check(activeCarrier, prim);
        idle(150);
        rd(`HSP_REG_EVT_CNT, d);
        check(d, 32'h1);
        check(evCount, 1);
        $display("test revert done");
        finish_test();
    end
endmodule
